// File: shared/clock_standby_defines.svh
// register map, field positions, reset values and timing for the clock unit
`ifndef CLOCK_STANDBY_DEFINES_SVH
`define CLOCK_STANDBY_DEFINES_SVH

`define CS_ADDR_W            12
`define CS_OFF_SYSTEM        12'h000
`define CS_OFF_OSC           12'h004
`define CS_OFF_STANDBY       12'h008
`define CS_OFF_PLL_USE        12'h00C

`define CS_SYS_KEEP_LSB      16
`define CS_SYS_PSRC_BIT      12
`define CS_SYS_PRE_LSB       8
`define CS_SYS_GEAR_LSB      0
`define CS_SYS_KEEP_RST      2'h1

`define CS_OSC_COUNT_LSB     20
`define CS_OSC_KEEP_LSB      16
`define CS_OSC_XEN_BIT       8
`define CS_OSC_SRCB_BIT      9
`define CS_OSC_SRCA_BIT      3
`define CS_OSC_RUN_BIT       2
`define CS_OSC_FLAG_BIT      1
`define CS_OSC_START_BIT     0
`define CS_OSC_COUNT_RST     12'h800
`define CS_OSC_KEEP_RST      4'h1

`define CS_STB_DRIVE_BIT     16
`define CS_STB_RSV17_BIT     17
`define CS_STB_RESTART_BIT   8
`define CS_STB_RSV9_BIT      9
`define CS_STB_MODE_LSB      0
`define CS_STB_MODE_RST      3'h3
`define CS_MODE_STOP         3'h1
`define CS_MODE_IDLE         3'h3

`define CS_PLL_KEEP_RST      15'h509F
`define CS_PLL_USE_BIT       0

`define CS_GEAR_DIV2         3'h4
`define CS_GEAR_DIV4         3'h5
`define CS_GEAR_DIV8         3'h6
`define CS_GEAR_DIV16        3'h7
`define CS_PRE_MAX           3'h5

`define CS_PLL_FACTOR        8
`define CS_WARMUP_SHIFT      4

`endif

// File: shared/clock_standby_pkg.sv
// types shared by the clock and standby control unit
`default_nettype none
package clock_standby_pkg;

    typedef enum logic [1:0] {
        MODE_RUN,
        MODE_IDLE,
        MODE_STOP,
        MODE_WARMUP
    } power_state_t;

endpackage

`default_nettype wire

// File: hdl/tick_divider.sv
// clock-enable divider by a power of two, switching only at a period boundary
`timescale 1ns/100ps
`default_nettype none

module tick_divider #(
    parameter int SHIFT_W = 3,
    parameter int CNT_W   = 5
)(
    // clock and reset
    input  wire logic               pclk,
    input  wire logic               presetn,
    // divider control
    input  wire logic [SHIFT_W-1:0] shift,
    input  wire logic               tick_in,
    output logic                    tick_out
);

    logic [CNT_W-1:0]   cnt_reg;
    logic [CNT_W-1:0]   cnt_next;
    logic [SHIFT_W-1:0] shift_reg;
    logic [SHIFT_W-1:0] shift_next;
    logic               out_reg;
    logic               out_next;
    logic [CNT_W-1:0]   mask;

    always_comb
    begin
        mask       = CNT_W'((1 << shift_reg) - 1);
        cnt_next   = cnt_reg;
        shift_next = shift_reg;
        out_next   = 1'b0;
        if (tick_in)
        begin
            out_next = ((cnt_reg & mask) == '0);
            // a new ratio is taken only on the last input tick of a period
            if ((cnt_reg & mask) == mask)
            begin
                cnt_next   = '0;
                shift_next = shift;
            end
            else
            begin
                cnt_next = CNT_W'(cnt_reg + 1'b1);
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_reg   <= '0;
            shift_reg <= '0;
            out_reg   <= 1'b0;
        end
        else
        begin
            cnt_reg   <= cnt_next;
            shift_reg <= shift_next;
            out_reg   <= out_next;
        end
    end

    assign tick_out = out_reg;

endmodule

`default_nettype wire

// File: hdl/clock_standby_pll_warmup_ctrl.sv
// clock tree, standby mode, pll select and warm-up timer with apb registers
`timescale 1ns/100ps
`default_nettype none
`include "clock_standby_defines.svh"

module clock_standby_pll_warmup_ctrl
    import clock_standby_pkg::*;
#(
    parameter int OSC_DIV     = 16,
    parameter int INT_OSC_DIV = 20,
    parameter int WARMUP_W    = 16
)(
    // clock and reset
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    // apb slave
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [`CS_ADDR_W-1:0] paddr,
    input  wire logic [31:0]           pwdata,
    output logic [31:0]                prdata,
    output logic                       pready,
    output logic                       pslverr,
    // processor power handshake
    input  wire logic                  wfi_request,
    input  wire logic                  wake_interrupt,
    // clock enables
    output logic                       hs_clk_en,
    output logic                       sys_clk_en,
    output logic                       cpu_clk_en,
    output logic                       periph_clk_en,
    output logic                       prescaler_clk_en,
    // mode status
    output logic                       stop_active,
    output logic                       idle_active,
    output logic                       stop_pins_driven,
    output logic                       osc_restart_enable
);

    localparam int PLL_STEP = OSC_DIV / `CS_PLL_FACTOR;

    // register fields
    logic [1:0]  sys_keep_reg, sys_keep_next;
    logic        psrc_reg, psrc_next;
    logic [2:0]  pre_reg, pre_next;
    logic [2:0]  gear_reg, gear_next;
    logic [11:0] wcount_reg, wcount_next;
    logic [3:0]  osc_keep_reg, osc_keep_next;
    logic        xen_reg, xen_next;
    logic        srcb_reg, srcb_next;
    logic        srca_reg, srca_next;
    logic        pll_run_reg, pll_run_next;
    logic        drive_reg, drive_next;
    logic        rsv17_reg, rsv17_next;
    logic        restart_reg, restart_next;
    logic        rsv9_reg, rsv9_next;
    logic [2:0]  mode_sel_reg, mode_sel_next;
    logic [14:0] pll_keep_reg, pll_keep_next;
    logic        pll_use_reg, pll_use_next;
    logic [31:0] rdata_reg, rdata_next;
    // mode and warm-up
    power_state_t         state_reg, state_next;
    logic                 busy_reg, busy_next;
    logic [WARMUP_W-1:0]  wcnt_reg, wcnt_next;
    // tick sources
    logic [7:0]  osc_cnt_reg, osc_cnt_next;
    logic [7:0]  int_cnt_reg, int_cnt_next;

    logic        wr_en, setup, mapped, start_wr;
    logic        osc_tick, pll_tick, int_tick, hs_tick, src_tick;
    logic        gear_tick, periph_tick, pre_tick;
    logic [2:0]  gear_shift, pre_shift;
    logic [WARMUP_W-1:0] target;
    logic        done;

    assign setup  = psel && !penable;
    assign wr_en  = psel && penable && pwrite;
    assign mapped = (paddr == `CS_OFF_SYSTEM) || (paddr == `CS_OFF_OSC) ||
                    (paddr == `CS_OFF_STANDBY) || (paddr == `CS_OFF_PLL_USE);
    assign start_wr = wr_en && (paddr == `CS_OFF_OSC) &&
                      pwdata[`CS_OSC_START_BIT];

    // register writes
    always_comb
    begin
        sys_keep_next = sys_keep_reg;
        psrc_next     = psrc_reg;
        pre_next      = pre_reg;
        gear_next     = gear_reg;
        wcount_next   = wcount_reg;
        osc_keep_next = osc_keep_reg;
        xen_next      = xen_reg;
        srcb_next     = srcb_reg;
        srca_next     = srca_reg;
        pll_run_next  = pll_run_reg;
        drive_next    = drive_reg;
        rsv17_next    = rsv17_reg;
        restart_next  = restart_reg;
        rsv9_next     = rsv9_reg;
        mode_sel_next = mode_sel_reg;
        pll_keep_next = pll_keep_reg;
        pll_use_next  = pll_use_reg;
        if (wr_en)
        begin
            case (paddr)
                `CS_OFF_SYSTEM:
                begin
                    sys_keep_next = pwdata[`CS_SYS_KEEP_LSB +: 2];
                    psrc_next     = pwdata[`CS_SYS_PSRC_BIT];
                    pre_next      = pwdata[`CS_SYS_PRE_LSB +: 3];
                    gear_next     = pwdata[`CS_SYS_GEAR_LSB +: 3];
                end
                `CS_OFF_OSC:
                begin
                    wcount_next   = pwdata[`CS_OSC_COUNT_LSB +: 12];
                    osc_keep_next = pwdata[`CS_OSC_KEEP_LSB +: 4];
                    xen_next      = pwdata[`CS_OSC_XEN_BIT];
                    srcb_next     = pwdata[`CS_OSC_SRCB_BIT];
                    srca_next     = pwdata[`CS_OSC_SRCA_BIT];
                    pll_run_next  = pwdata[`CS_OSC_RUN_BIT];
                end
                `CS_OFF_STANDBY:
                begin
                    drive_next    = pwdata[`CS_STB_DRIVE_BIT];
                    rsv17_next    = pwdata[`CS_STB_RSV17_BIT];
                    restart_next  = pwdata[`CS_STB_RESTART_BIT];
                    rsv9_next     = pwdata[`CS_STB_RSV9_BIT];
                    mode_sel_next = pwdata[`CS_STB_MODE_LSB +: 3];
                end
                `CS_OFF_PLL_USE:
                begin
                    pll_keep_next = pwdata[15:1];
                    pll_use_next  = pwdata[`CS_PLL_USE_BIT];
                end
                default:
                begin
                    pll_use_next = pll_use_reg;
                end
            endcase
        end
    end

    // read data is captured in the setup cycle and shown in the access cycle
    always_comb
    begin
        rdata_next = rdata_reg;
        if (setup)
        begin
            case (paddr)
                `CS_OFF_SYSTEM:
                    rdata_next = {14'h0000, sys_keep_reg, 3'h0, psrc_reg,
                                  1'b0, pre_reg, 5'h00, gear_reg};
                `CS_OFF_OSC:
                    rdata_next = {wcount_reg, osc_keep_reg, 6'h00, srcb_reg,
                                  xen_reg, 4'h0, srca_reg, pll_run_reg,
                                  busy_reg, 1'b0};
                `CS_OFF_STANDBY:
                    rdata_next = {14'h0000, rsv17_reg, drive_reg, 6'h00,
                                  rsv9_reg, restart_reg, 5'h00, mode_sel_reg};
                `CS_OFF_PLL_USE:
                    rdata_next = {16'h0000, pll_keep_reg, pll_use_reg};
                default:
                    rdata_next = 32'h00000000;
            endcase
        end
    end

    // oscillator and internal oscillator enables; pll is oscillator times eight
    always_comb
    begin
        osc_cnt_next = osc_cnt_reg;
        int_cnt_next = (int_cnt_reg == 8'(INT_OSC_DIV - 1)) ? 8'h00
                       : 8'(int_cnt_reg + 1'b1);
        // oscillator halts in STOP and restarts on wake
        if (state_reg != MODE_STOP)
            osc_cnt_next = (osc_cnt_reg == 8'(OSC_DIV - 1)) ? 8'h00
                           : 8'(osc_cnt_reg + 1'b1);
    end

    assign osc_tick = (state_reg != MODE_STOP) && (osc_cnt_reg == 8'h00);
    assign int_tick = (int_cnt_reg == 8'h00);
    assign pll_tick = pll_run_reg && (state_reg != MODE_STOP) &&
                      ((osc_cnt_reg % 8'(PLL_STEP)) == 8'h00);
    assign hs_tick  = pll_use_reg ? pll_tick : osc_tick;

    // gear and prescale codes to power-of-two shifts; reserved codes undivided
    always_comb
    begin
        case (gear_reg)
            `CS_GEAR_DIV2:  gear_shift = 3'h1;
            `CS_GEAR_DIV4:  gear_shift = 3'h2;
            `CS_GEAR_DIV8:  gear_shift = 3'h3;
            `CS_GEAR_DIV16: gear_shift = 3'h4;
            default:        gear_shift = 3'h0;
        endcase
        pre_shift = (pre_reg <= `CS_PRE_MAX) ? pre_reg : 3'h0;
    end

    tick_divider #(.SHIFT_W(3), .CNT_W(5)) gear_div (
        .pclk     (pclk),
        .presetn  (presetn),
        .shift    (gear_shift),
        .tick_in  (hs_tick),
        .tick_out (gear_tick)
    );

    assign periph_tick = psrc_reg ? hs_tick : gear_tick;

    tick_divider #(.SHIFT_W(3), .CNT_W(5)) pre_div (
        .pclk     (pclk),
        .presetn  (presetn),
        .shift    (pre_shift),
        .tick_in  (periph_tick),
        .tick_out (pre_tick)
    );

    // power mode and warm-up timer
    assign src_tick = srcb_reg ? osc_tick : int_tick;
    assign target   = WARMUP_W'({wcount_reg, 4'h0});
    assign done     = busy_reg && src_tick &&
                      (WARMUP_W'(wcnt_reg + 1'b1) >= target);

    always_comb
    begin
        state_next = state_reg;
        busy_next  = busy_reg;
        wcnt_next  = wcnt_reg;
        if (busy_reg && src_tick)
            wcnt_next = WARMUP_W'(wcnt_reg + 1'b1);
        if (done)
            busy_next = 1'b0;
        case (state_reg)
            MODE_RUN:
            begin
                // reserved mode codes leave the core running
                if (wfi_request && mode_sel_reg == `CS_MODE_IDLE)
                    state_next = MODE_IDLE;
                else if (wfi_request && mode_sel_reg == `CS_MODE_STOP)
                    state_next = MODE_STOP;
            end
            MODE_IDLE:
            begin
                if (wake_interrupt)
                    state_next = MODE_RUN;
            end
            MODE_STOP:
            begin
                if (wake_interrupt)
                begin
                    state_next = MODE_WARMUP;
                    busy_next  = 1'b1;
                    wcnt_next  = '0;
                end
            end
            MODE_WARMUP:
            begin
                if (!busy_reg)
                    state_next = MODE_RUN;
            end
            default:
            begin
                state_next = MODE_RUN;
            end
        endcase
        // a start write beats a completion in the same cycle
        if (start_wr)
        begin
            busy_next = 1'b1;
            wcnt_next = '0;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sys_keep_reg <= `CS_SYS_KEEP_RST;
            psrc_reg     <= 1'b0;
            pre_reg      <= 3'h0;
            gear_reg     <= 3'h0;
            wcount_reg   <= `CS_OSC_COUNT_RST;
            osc_keep_reg <= `CS_OSC_KEEP_RST;
            xen_reg      <= 1'b0;
            srcb_reg     <= 1'b0;
            srca_reg     <= 1'b0;
            pll_run_reg  <= 1'b0;
            drive_reg    <= 1'b0;
            rsv17_reg    <= 1'b0;
            restart_reg  <= 1'b1;
            rsv9_reg     <= 1'b0;
            mode_sel_reg <= `CS_STB_MODE_RST;
            pll_keep_reg <= `CS_PLL_KEEP_RST;
            pll_use_reg  <= 1'b0;
            rdata_reg    <= 32'h00000000;
            state_reg    <= MODE_RUN;
            busy_reg     <= 1'b0;
            wcnt_reg     <= '0;
            osc_cnt_reg  <= 8'h00;
            int_cnt_reg  <= 8'h00;
        end
        else
        begin
            sys_keep_reg <= sys_keep_next;
            psrc_reg     <= psrc_next;
            pre_reg      <= pre_next;
            gear_reg     <= gear_next;
            wcount_reg   <= wcount_next;
            osc_keep_reg <= osc_keep_next;
            xen_reg      <= xen_next;
            srcb_reg     <= srcb_next;
            srca_reg     <= srca_next;
            pll_run_reg  <= pll_run_next;
            drive_reg    <= drive_next;
            rsv17_reg    <= rsv17_next;
            restart_reg  <= restart_next;
            rsv9_reg     <= rsv9_next;
            mode_sel_reg <= mode_sel_next;
            pll_keep_reg <= pll_keep_next;
            pll_use_reg  <= pll_use_next;
            rdata_reg    <= rdata_next;
            state_reg    <= state_next;
            busy_reg     <= busy_next;
            wcnt_reg     <= wcnt_next;
            osc_cnt_reg  <= osc_cnt_next;
            int_cnt_reg  <= int_cnt_next;
        end
    end

    assign prdata             = rdata_reg;
    assign pready             = 1'b1;
    assign pslverr            = psel && penable && !mapped;
    assign hs_clk_en          = hs_tick;
    assign sys_clk_en         = gear_tick &&
                                (state_reg != MODE_WARMUP);
    assign cpu_clk_en         = sys_clk_en && (state_reg == MODE_RUN);
    assign periph_clk_en      = periph_tick && (state_reg != MODE_WARMUP);
    assign prescaler_clk_en   = pre_tick && (state_reg != MODE_WARMUP);
    assign stop_active        = (state_reg == MODE_STOP);
    assign idle_active        = (state_reg == MODE_IDLE);
    assign stop_pins_driven   = drive_reg;
    assign osc_restart_enable = restart_reg;

    // checks
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic [3:0] pll_in_period;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pll_in_period <= 4'h0;
        else
            pll_in_period <= osc_tick ? 4'h1 : 4'(pll_in_period + pll_tick);
    end

    // high-speed ticks since the gear went undivided; the divider has
    // surely taken the new ratio after one full sixteen-tick period
    logic [4:0] gear_zero_ticks;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            gear_zero_ticks <= 5'h00;
        else if (gear_shift != 3'h0)
            gear_zero_ticks <= 5'h00;
        else if (hs_tick && gear_zero_ticks != 5'h1F)
            gear_zero_ticks <= 5'(gear_zero_ticks + 1'b1);
    end

    pll_octuple_a: assert property (osc_tick && pll_run_reg &&
        $past(pll_run_reg) && $past(pll_run_reg, OSC_DIV) &&
        $past(osc_tick, OSC_DIV) && !$past(stop_active)
        |-> pll_in_period == 4'h8) else $error("pll not eight per osc");
    pll_stop_off_a: assert property (stop_active |-> !pll_tick && !hs_tick)
        else $error("pll ticks in stop");
    hs_select_a: assert property (!pll_use_reg |-> hs_tick == osc_tick)
        else $error("high-speed not oscillator");
    wake_warm_a: assert property (stop_active && wake_interrupt
        |=> state_reg == MODE_WARMUP && busy_reg) else $error("no warm-up");
    warm_hold_a: assert property (state_reg == MODE_WARMUP |-> !sys_clk_en)
        else $error("clock leaked in warm-up");
    start_busy_a: assert property (start_wr |=> busy_reg)
        else $error("start did not set flag");
    flag_done_a: assert property (done && !start_wr && target != '0
        |=> !busy_reg && wcnt_reg == target)
        else $error("flag after done");
    rsv_mode_a: assert property (state_reg == MODE_RUN && wfi_request &&
        mode_sel_reg != `CS_MODE_STOP && mode_sel_reg != `CS_MODE_IDLE
        |=> state_reg == MODE_RUN)
        else $error("reserved mode entered");
    gear_undiv_a: assert property (gear_shift == 3'h0 &&
        gear_zero_ticks > 5'h10 && $past(hs_tick) |-> gear_tick)
        else $error("undivided gear lost tick");

endmodule

`default_nettype wire

// File: tb/tb.sv
// self-checking bench for the clock, standby and warm-up control unit
`timescale 1ns/100ps
`default_nettype none
`include "clock_standby_defines.svh"

module tb;
    import clock_standby_pkg::*;

    typedef struct {
        logic [2:0] gear;
        logic [2:0] pre;
        logic       src;
        int         sys_n;
        int         pre_n;
    } row_t;

    logic        pclk, presetn, psel, penable, pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic        pready, pslverr, wfi_request, wake_interrupt, e;
    logic        hs_clk_en, sys_clk_en, cpu_clk_en, periph_clk_en;
    logic        prescaler_clk_en, stop_active, idle_active;
    logic        stop_pins_driven, osc_restart_enable;
    int          mismatches, checks, cycles, ns, np, nh, nc, nq;
    row_t        rows[7];

    clock_standby_pll_warmup_ctrl dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .wfi_request(wfi_request),
        .wake_interrupt(wake_interrupt), .hs_clk_en(hs_clk_en),
        .sys_clk_en(sys_clk_en), .cpu_clk_en(cpu_clk_en),
        .periph_clk_en(periph_clk_en), .prescaler_clk_en(prescaler_clk_en),
        .stop_active(stop_active), .idle_active(idle_active),
        .stop_pins_driven(stop_pins_driven),
        .osc_restart_enable(osc_restart_enable)
    );

    initial
    begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    task test_done;
        if (mismatches == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    always @(posedge pclk)
    begin
        cycles++;
        if (cycles == 95000)
        begin
            mismatches++;
            test_done;
        end
    end

    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one apb transfer; request held until pready is seen high
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // counts clock-enable pulses over n cycles
    task run(input int n);
        ns = 0; np = 0; nh = 0; nc = 0; nq = 0;
        repeat (n)
        begin
            @(posedge pclk);
            ns += (sys_clk_en === 1'b1);
            np += (prescaler_clk_en === 1'b1);
            nh += (hs_clk_en === 1'b1);
            nc += (cpu_clk_en === 1'b1);
            nq += (periph_clk_en === 1'b1);
        end
    endtask

    task pulse(input logic wake);
        @(posedge pclk);
        if (wake) wake_interrupt <= 1'b1; else wfi_request <= 1'b1;
        @(posedge pclk);
        wake_interrupt <= 1'b0;
        wfi_request <= 1'b0;
        @(posedge pclk);
    endtask

    task do_reset;
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
    endtask

    initial
    begin
        {presetn, psel, penable, pwrite, wfi_request, wake_interrupt} = 0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        rows = '{'{3'h0, 3'h0, 1, 256, 256}, '{3'h4, 3'h1, 1, 128, 128},
                 '{3'h5, 3'h2, 1, 64, 64}, '{3'h6, 3'h3, 1, 32, 32},
                 '{3'h7, 3'h4, 1, 16, 16}, '{3'h0, 3'h5, 1, 256, 8},
                 '{3'h4, 3'h1, 0, 128, 64}};
        do_reset;
        // pll on, settle about 200 us on the warm-up timer, then select it
        apb(1, `CS_OFF_OSC, 32'h09D1_0205);
        r = 32'h0000_0002;
        while (r[1] !== 1'b0) apb(0, `CS_OFF_OSC, 0);
        apb(1, `CS_OFF_PLL_USE, 32'h0000_A13F);
        apb(0, `CS_OFF_PLL_USE, 0);
        chk(r, 32'h0000_A13F);
        foreach (rows[i])
        begin
            apb(1, `CS_OFF_SYSTEM, 32'h0001_0000 | (32'(rows[i].src) << 12)
                | (32'(rows[i].pre) << 8) | 32'(rows[i].gear));
            run(100);
            run(512);
            chk(nh, 256);
            chk(ns, rows[i].sys_n);
            chk(np, rows[i].pre_n);
        end
        // warm-up of 1 x 16 external oscillator ticks
        apb(1, `CS_OFF_OSC, 32'h0011_0205);
        apb(0, `CS_OFF_OSC, 0);
        chk(r[1], 1'b1);
        run(180);
        apb(0, `CS_OFF_OSC, 0);
        chk(r[1], 1'b1);
        repeat (30) if (r[1] !== 1'b0) apb(0, `CS_OFF_OSC, 0);
        chk(r & 32'hFFFF_FFFE, 32'h0011_0204);
        // stop entry with a warm-up long enough for the pll, then wake
        apb(1, `CS_OFF_OSC, 32'h09D1_0204);
        apb(1, `CS_OFF_STANDBY, 32'h0001_0101);
        @(posedge pclk);
        chk(stop_pins_driven, 1'b1);
        chk(osc_restart_enable, 1'b1);
        pulse(0);
        run(40);
        chk(stop_active, 1'b1);
        chk(nh + ns, 0);
        pulse(1);
        run(40100);
        chk(nc + nq, 0);
        run(200);
        chk(nc > 0, 1'b1);
        // idle entry keeps peripherals running
        apb(1, `CS_OFF_STANDBY, 32'h0000_0103);
        pulse(0);
        run(64);
        chk({idle_active, stop_active, nc == 0, np > 0}, 4'hB);
        pulse(1);
        chk(idle_active, 1'b0);
        // reserved mode codes enter no low-power state
        for (int i = 0; i < 8; i++)
        begin
            if (i == 1 || i == 3) continue;
            apb(1, `CS_OFF_STANDBY, 32'h0000_0100 | 32'(i));
            apb(0, `CS_OFF_STANDBY, 0);
            chk(r, 32'h0000_0100 | 32'(i));
            pulse(0);
            chk(stop_active | idle_active, 1'b0);
        end
        apb(1, `CS_OFF_STANDBY, 32'hFFFF_FFFF);
        apb(0, `CS_OFF_STANDBY, 0);
        chk(r, 32'h0003_0307);
        apb(0, 12'h010, 0);
        chk(e, 1'b1);
        chk(r, 32'h0000_0000);
        // pll shut-down: drop use, see it read back 0, then stop the pll
        apb(1, `CS_OFF_PLL_USE, 32'h0000_A13E);
        apb(0, `CS_OFF_PLL_USE, 0);
        chk(r, 32'h0000_A13E);
        apb(1, `CS_OFF_OSC, 32'h09D1_0200);
        run(160);
        chk(nh, 10);
        // second reset restores defaults
        do_reset;
        apb(0, `CS_OFF_SYSTEM, 0);
        chk(r, 32'h0001_0000);
        apb(0, `CS_OFF_OSC, 0);
        chk(r, 32'h8001_0000);
        apb(0, `CS_OFF_STANDBY, 0);
        chk(r, 32'h0000_0103);
        apb(0, `CS_OFF_PLL_USE, 0);
        chk(r, 32'h0000_A13E);
        run(160);
        chk(nh, 10);
        chk(ns, 10);
        chk(np, 10);
        chk(nc, 10);
        test_done;
    end
endmodule
`default_nettype wire
